// File: asi_irq_unit.sv
// Interrupt flags, enables and vector generator of the auxiliary supply system.
//
// Summary of operation
// - Seven sources: any switch, three switched-to, two drops, monitor done.
// - Any completed switch to a different supply sets the any-switch flag.
// - Any-switch flag with its NMI enable raises the NMI request, ignoring GLOBAL_IRQ_ENABLE.
// - Without NMI enable, any-switch is maskable only with its enable and GLOBAL_IRQ_ENABLE.
// - Switching onto a supply sets that supply's switched-to flag.
// - Switched-to flags request an interrupt only with own enable and GLOBAL_IRQ_ENABLE.
// - Okay falling one to zero under hardware monitoring sets the drop flag.
// - Drop flags request an interrupt only with own enable and GLOBAL_IRQ_ENABLE.
// - Each completed monitoring cycle sets the monitor flag.
// - Monitor flag requests an interrupt only with its enable and GLOBAL_IRQ_ENABLE.
// - Maskable sources merge into one vector naming highest enabled pending one.
// - Disabled pending sources do not affect the vector.
// - Reading the vector clears the highest enabled pending flag.
// - Any write to the vector clears every flag.
// - Software may clear each flag directly through the flag register.
// - Any-switch flag routed as NMI feeds the shared user NMI collector.
// - With both enables set, NMI path wins but the vector still shows the flag.
// - Supply index 0 primary, 1 first auxiliary, 2 second auxiliary.
// - Mode bit zero means hardware monitoring; one means software okay state.
`timescale 1ns/1ns
`default_nettype none
`include "asi_defs.svh"
module asi_irq_unit
   import asi_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_clk_en,
   input wire asi_supply_t i_supply,
   input wire logic i_global_irq_enable,
   input wire logic [`ASI_ADDR_W-1:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [`ASI_ADDR_W-1:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic o_irq_request,
   output logic o_user_nmi_request,
   output logic [`ASI_NUM_SRC-1:0] o_pending_flags
);

   asi_state_t st_ff;
   asi_state_t nxt_st;

   // Vector generator inputs, derived from the current state.
   logic [`ASI_NUM_SRC-1:0] vec_mask;
   logic [`ASI_NUM_SRC-1:0] vec_pending;
   logic [`ASI_NUM_SRC-1:0] vec_onehot;
   logic [3:0] vec_code;
   logic [`ASI_NUM_SRC-1:0] hw_set;
   logic [2:0] switched_to;
   logic [1:0] drop_event;
   logic aw_take;
   logic w_take;
   logic ar_take;
   logic [`ASI_NUM_SRC-1:0] maskable;

   // The lowest pending bit wins; its vector is twice its position plus two.
   always_comb begin
      vec_mask = st_ff.enables[`ASI_NUM_SRC-1:0];
      vec_pending = st_ff.flags & vec_mask;
      vec_onehot = '0;
      vec_code = `ASI_VEC_NONE;
      for (int i = `ASI_NUM_SRC - 1; i >= 0; i--) begin
         if (vec_pending[i]) begin
            vec_onehot = '0;
            vec_onehot[i] = 1'b1;
            vec_code = `ASI_VEC_STEP * (4'(i) + 4'h1);
         end
      end
   end

   // Hardware set events, one per source.
   always_comb begin
      switched_to = '0;
      if (i_supply.switch_done) begin
         unique case (i_supply.new_supply)
            `ASI_IDX_PRIMARY: switched_to[0] = 1'b1;
            `ASI_IDX_AUX_ONE: switched_to[1] = 1'b1;
            `ASI_IDX_AUX_TWO: switched_to[2] = 1'b1;
            default: switched_to = '0;
         endcase
      end
      // A falling okay counts only while the supply is hardware monitored.
      drop_event = st_ff.okay_prev & ~i_supply.okay & ~i_supply.mode;
      hw_set = '0;
      hw_set[`ASI_BIT_ANY_SW] = i_supply.switch_done;
      hw_set[`ASI_BIT_PRI_SW +: 3] = switched_to;
      hw_set[`ASI_BIT_DROP1 +: 2] = drop_event;
      hw_set[`ASI_BIT_MON] = i_supply.monitor_done;
   end

   // Bus handshakes seen this cycle.
   assign aw_take = i_awvalid & st_ff.awready;
   assign w_take = i_wvalid & st_ff.wready;
   assign ar_take = i_arvalid & st_ff.arready;

   // Next state: bus slave, flag updates and request outputs.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.okay_prev = i_supply.okay;
      // Address and data are captured independently, in either order.
      if (aw_take) begin
         nxt_st.aw_held = 1'b1;
         nxt_st.aw_addr = i_awaddr;
      end
      if (w_take) begin
         nxt_st.w_held = 1'b1;
         nxt_st.w_data = i_wdata[7:0];
         nxt_st.w_lane0 = i_wstrb[0];
      end
      if (st_ff.bvalid && i_bready) begin
         nxt_st.bvalid = 1'b0;
      end
      // The write acts once both halves are held and no response is owed.
      if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
         nxt_st.aw_held = 1'b0;
         nxt_st.w_held = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = `ASI_RESP_OKAY;
         unique case (st_ff.aw_addr)
            `ASI_OFS_FLAGS: begin
               if (st_ff.w_lane0) begin
                  nxt_st.flags = st_ff.w_data[`ASI_NUM_SRC-1:0];
               end
            end
            `ASI_OFS_ENABLE: begin
               if (st_ff.w_lane0) begin
                  nxt_st.enables = st_ff.w_data;
               end
            end
            `ASI_OFS_VECTOR: begin
               nxt_st.flags = `ASI_FLAGS_RST;
            end
            `ASI_OFS_STATUS: begin
               nxt_st.bresp = `ASI_RESP_OKAY;
            end
            default: begin
               nxt_st.bresp = `ASI_RESP_SLVERR;
            end
         endcase
      end
      // Read path: data are fixed at the address handshake.
      if (st_ff.rvalid && i_rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (ar_take) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp = `ASI_RESP_OKAY;
         nxt_st.rdata = '0;
         unique case (i_araddr)
            `ASI_OFS_FLAGS: begin
               nxt_st.rdata[`ASI_NUM_SRC-1:0] = st_ff.flags;
            end
            `ASI_OFS_ENABLE: begin
               nxt_st.rdata[7:0] = st_ff.enables;
            end
            `ASI_OFS_VECTOR: begin
               nxt_st.rdata[3:0] = vec_code;
               nxt_st.flags = nxt_st.flags & ~vec_onehot;
            end
            `ASI_OFS_STATUS: begin
               nxt_st.rdata[3:0] = {i_supply.mode, i_supply.okay};
            end
            default: begin
               nxt_st.rresp = `ASI_RESP_SLVERR;
            end
         endcase
      end
      // Hardware events win over any clear in the same cycle.
      nxt_st.flags = nxt_st.flags | hw_set;
      nxt_st.awready = ~nxt_st.aw_held & ~nxt_st.bvalid;
      nxt_st.wready = ~nxt_st.w_held & ~nxt_st.bvalid;
      nxt_st.arready = ~nxt_st.rvalid;
      // The any-switch flag leaves the maskable path while routed as NMI.
      maskable = nxt_st.flags & nxt_st.enables[`ASI_NUM_SRC-1:0];
      maskable[`ASI_BIT_ANY_SW] = maskable[`ASI_BIT_ANY_SW]
         & ~nxt_st.enables[`ASI_BIT_NMI_EN];
      nxt_st.irq = i_global_irq_enable & (|maskable);
      nxt_st.nmi = nxt_st.flags[`ASI_BIT_ANY_SW]
         & nxt_st.enables[`ASI_BIT_NMI_EN];
   end

   // State register, frozen while the clock enable is low and reset is not asserted.
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         st_ff <= '0;
         st_ff.flags <= `ASI_FLAGS_RST;
         st_ff.enables <= `ASI_ENABLE_RST;
      end else if (i_clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // Outputs come straight from the state register.
   assign o_awready = st_ff.awready;
   assign o_wready = st_ff.wready;
   assign o_bvalid = st_ff.bvalid;
   assign o_bresp = st_ff.bresp;
   assign o_arready = st_ff.arready;
   assign o_rvalid = st_ff.rvalid;
   assign o_rdata = st_ff.rdata;
   assign o_rresp = st_ff.rresp;
   assign o_irq_request = st_ff.irq;
   assign o_user_nmi_request = st_ff.nmi;
   assign o_pending_flags = st_ff.flags;

endmodule : asi_irq_unit
`default_nettype wire

// File: asi_defs.svh
// Address map, field positions, reset values and vector codes of the supply interrupt unit.
`ifndef ASI_DEFS_SVH
`define ASI_DEFS_SVH
`define ASI_ADDR_W 5
`define ASI_OFS_FLAGS 5'h00
`define ASI_OFS_ENABLE 5'h04
`define ASI_OFS_VECTOR 5'h08
`define ASI_OFS_STATUS 5'h0c
`define ASI_NUM_SRC 7
`define ASI_BIT_ANY_SW 0
`define ASI_BIT_PRI_SW 1
`define ASI_BIT_DROP1 4
`define ASI_BIT_MON 6
`define ASI_BIT_NMI_EN 7
`define ASI_IDX_PRIMARY 2'h0
`define ASI_IDX_AUX_ONE 2'h1
`define ASI_IDX_AUX_TWO 2'h2
`define ASI_FLAGS_RST 7'h00
`define ASI_ENABLE_RST 8'h00
`define ASI_VEC_NONE 4'h0
`define ASI_VEC_STEP 4'h2
`define ASI_RESP_OKAY 2'h0
`define ASI_RESP_SLVERR 2'h2
`endif

// File: asi_pkg.sv
// Types shared by the supply interrupt unit.
`default_nettype none
package asi_pkg;
   `include "asi_defs.svh"
   // Event and level signals from the supply switching logic, same clock.
   typedef struct packed {
      logic switch_done;
      logic [1:0] new_supply;
      logic [1:0] okay;
      logic [1:0] mode;
      logic monitor_done;
   } asi_supply_t;
   // Complete state of the interrupt unit.
   typedef struct packed {
      logic [`ASI_NUM_SRC-1:0] flags;
      logic [7:0] enables;
      logic [1:0] okay_prev;
      logic aw_held;
      logic [`ASI_ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [7:0] w_data;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic irq;
      logic nmi;
   } asi_state_t;
endpackage : asi_pkg
`default_nettype wire

// File: asi_irq_unit_monitor.sv
// Port checks of the supply interrupt unit.
`timescale 1ns/1ns
`default_nettype none
`include "asi_defs.svh"
module asi_irq_unit_monitor
   import asi_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset,
   input wire logic i_clk_en,
   input wire asi_supply_t i_supply,
   input wire logic i_global_irq_enable,
   input wire logic i_arvalid,
   input wire logic i_rready,
   input wire logic o_arready,
   input wire logic o_rvalid,
   input wire logic [31:0] o_rdata,
   input wire logic o_irq_request,
   input wire logic o_user_nmi_request,
   input wire logic [`ASI_NUM_SRC-1:0] o_pending_flags
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset || !i_clk_en);
   any_switch_a: assert property (i_supply.switch_done |=> o_pending_flags[0])
      else $error("switch flag not set");
   per_supply_a: assert property (i_supply.switch_done && i_supply.new_supply != 2'h3
      |=> o_pending_flags[$past(i_supply.new_supply) + 1]) else $error("supply flag not set");
   drop_one_a: assert property (!$past(i_reset) && $fell(i_supply.okay[0])
      && !i_supply.mode[0] |=> o_pending_flags[4]) else $error("drop flag not set");
   monitor_a: assert property (i_supply.monitor_done |=> o_pending_flags[6])
      else $error("monitor flag not set");
   nmi_cause_a: assert property (o_user_nmi_request |-> o_pending_flags[0])
      else $error("nmi without flag");
   irq_gie_a: assert property (o_irq_request |-> $past(i_global_irq_enable))
      else $error("irq without global enable");
   read_answer_a: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read not answered");
   read_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data dropped");
endmodule : asi_irq_unit_monitor
bind asi_irq_unit asi_irq_unit_monitor i_mon (
   .i_core_clk(i_core_clk),
   .i_reset(i_reset),
   .i_clk_en(i_clk_en),
   .i_supply(i_supply),
   .i_global_irq_enable(i_global_irq_enable),
   .i_arvalid(i_arvalid),
   .i_rready(i_rready),
   .o_arready(o_arready),
   .o_rvalid(o_rvalid),
   .o_rdata(o_rdata),
   .o_irq_request(o_irq_request),
   .o_user_nmi_request(o_user_nmi_request),
   .o_pending_flags(o_pending_flags)
);
`default_nettype wire

// File: asi_cpu_model.sv
// Processor side: global enable and interrupt intake.
`timescale 1ns/1ns
`default_nettype none
module asi_cpu_model (
   input wire logic i_core_clk,
   input wire logic i_gie_set,
   input wire logic i_irq,
   input wire logic i_nmi,
   output logic o_gie,
   output logic o_took_nmi,
   output logic o_took_irq
);
   // The enable follows software; an NMI is taken whatever the enable says.
   always_ff @(posedge i_core_clk) begin
      o_gie <= i_gie_set;
      o_took_nmi <= i_nmi;
      o_took_irq <= i_irq & o_gie; // A maskable request is taken only while enabled.
   end
endmodule : asi_cpu_model
`default_nettype wire

// File: asi_irq_unit_tb.sv
// Self-checking bench of the supply interrupt unit.
`timescale 1ns/1ns
`default_nettype none
`include "asi_defs.svh"
module asi_irq_unit_tb
   import asi_pkg::*;
;
   logic clk = 1'h0, rst = 1'h1, gie_set = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0;
   logic arv = 1'h0, rready = 1'h0, awr, wrdy, bv, arr, rv, irq, nmi, global_irq_enable, took_nmi, took_irq;
   logic ce = 1'h1;
   asi_supply_t sup = '0;
   logic [4:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata, rd_d;
   logic [1:0] bresp, rresp, rd_r, wr_r;
   logic [6:0] flags;
   int num_errors = 0, total_checks = 0, cyc = 0;
   // Clock and hang limit.
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin num_errors++; complete_run(); end
   end
   asi_irq_unit i_asi_irq_unit (.i_core_clk(clk), .i_reset(rst), .i_clk_en(ce),
      .i_supply(sup), .i_global_irq_enable(global_irq_enable), .i_awaddr(awaddr), .i_awvalid(awv),
      .o_awready(awr), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wrdy),
      .o_bresp(bresp), .o_bvalid(bv), .i_bready(bready), .i_araddr(araddr),
      .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv),
      .i_rready(rready), .o_irq_request(irq), .o_user_nmi_request(nmi), .o_pending_flags(flags));
   asi_cpu_model i_asi_cpu_model (.i_core_clk(clk), .i_gie_set(gie_set), .i_irq(irq),
      .i_nmi(nmi), .o_gie(global_irq_enable), .o_took_nmi(took_nmi), .o_took_irq(took_irq));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task wr(input logic [4:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bready <= 1'h1;
      @(posedge clk);
      // Each channel is released only after the edge at which it was taken.
      while (awv || wv || bready) begin
         if (awv && awr) awv <= 1'h0;
         if (wv && wrdy) wv <= 1'h0;
         if (bready && bv) begin
            wr_r = bresp;
            bready <= 1'h0;
         end
         @(posedge clk);
      end
   endtask : wr
   task rc(input logic [4:0] a, input logic [31:0] e);
      araddr <= a;
      arv <= 1'h1;
      rready <= 1'h1;
      @(posedge clk);
      // Read data are taken at the edge at which valid and ready are both high.
      while (arv || rready) begin
         if (arv && arr) arv <= 1'h0;
         if (rready && rv) begin
            rd_d = rdata;
            rd_r = rresp;
            rready <= 1'h0;
         end
         @(posedge clk);
      end
      chk(rd_d, e);
   endtask : rc
   task ev(input logic sw, input logic [1:0] ns, input logic mon);
      sup.switch_done <= sw; sup.new_supply <= ns; sup.monitor_done <= mon;
      @(posedge clk);
      sup.switch_done <= 1'h0; sup.monitor_done <= 1'h0;
      @(posedge clk);
   endtask : ev
   // Switch onto aux one with all maskable enables, then drain by vector reads.
   task t_switch();
      gie_set <= 1'h1;
      wr(`ASI_OFS_ENABLE, 32'h7f);
      ev(1'h1, 2'h1, 1'h0);
      rc(`ASI_OFS_FLAGS, 32'h5);
      chk({took_irq, irq}, 2'h3);
      rc(`ASI_OFS_VECTOR, 32'h2);
      rc(`ASI_OFS_VECTOR, 32'h6);
      rc(`ASI_OFS_VECTOR, 32'h0);
      chk(flags, 7'h0);
      chk({took_irq, irq}, 2'h0);
   endtask : t_switch
   // Switch routed as NMI with the global enable off.
   task t_nmi();
      gie_set <= 1'h0;
      wr(`ASI_OFS_ENABLE, 32'h80);
      ev(1'h1, 2'h2, 1'h0);
      // The processor model takes the request one edge later.
      @(posedge clk);
      chk({took_nmi, nmi, irq}, 3'h6);
      rc(`ASI_OFS_VECTOR, 32'h0);
      chk(flags, 7'h9);
      gie_set <= 1'h1;
      wr(`ASI_OFS_ENABLE, 32'h81);
      chk({nmi, irq}, 2'h2);
      rc(`ASI_OFS_VECTOR, 32'h2);
      chk({nmi, flags}, 8'h08);
      wr(`ASI_OFS_ENABLE, 32'h01);
      ev(1'h1, 2'h0, 1'h0);
      chk({nmi, irq}, 2'h1);
      gie_set <= 1'h0;
      repeat (3) @(posedge clk);
      chk(irq, 1'h0);
   endtask : t_nmi
   // Drop under hardware monitoring only, monitor event, clears, unmapped read.
   task t_drop();
      sup.okay <= 2'h3;
      sup.mode <= 2'h2;
      @(posedge clk);
      sup.okay <= 2'h0;
      ev(1'h0, 2'h3, 1'h1);
      rc(`ASI_OFS_FLAGS, 32'h5b);
      wr(`ASI_OFS_FLAGS, 32'h0);
      ev(1'h0, 2'h3, 1'h1);
      rc(`ASI_OFS_FLAGS, 32'h40);
      rc(`ASI_OFS_STATUS, 32'h8);
      wr(`ASI_OFS_FLAGS, 32'h7f);
      wr(`ASI_OFS_VECTOR, 32'h0);
      chk(flags, 7'h0);
      chk(wr_r, `ASI_RESP_OKAY);
      // Events while the clock enable is low must leave every flag alone.
      ce <= 1'h0;
      ev(1'h1, 2'h0, 1'h1);
      chk(flags, 7'h0);
      ce <= 1'h1;
      rc(5'h10, 32'h0);
      chk(rd_r, `ASI_RESP_SLVERR);
   endtask : t_drop
   task complete_run();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   // Reset, then the scenarios in turn.
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      repeat (2) @(posedge clk);
      t_switch();
      t_nmi();
      t_drop();
      complete_run();
   end
endmodule : asi_irq_unit_tb
`default_nettype wire
